// ---- pkg/cte_pkg.sv ----
package cte_pkg;
	// Register port map: 0x00..0x1F are the general registers
	localparam logic [5:0] ADDR_PSW = 6'h20;
	localparam logic [5:0] ADDR_EXC_RETURN_PC = 6'h21;
	localparam logic [5:0] ADDR_EXC_SAVED_STATUS = 6'h22;
	localparam logic [5:0] ADDR_ECR = 6'h23;
	localparam logic [5:0] ADDR_PC = 6'h24;
	localparam logic [5:0] ADDR_STAT = 6'h25;
	localparam logic [5:0] ADDR_GR_END = 6'h1F;
	// System register identifiers
	localparam logic [4:0] SR_EXC_RETURN_PC = 5'h00;
	localparam logic [4:0] SR_EXC_SAVED_STATUS = 5'h01;
	localparam logic [4:0] SR_ECR = 5'h04;
	localparam logic [4:0] SR_PSW = 5'h05;
	// Status word bit positions and reset value
	localparam int PSW_Z = 0;
	localparam int PSW_S = 1;
	localparam int PSW_OV = 2;
	localparam int PSW_CY = 3;
	localparam int INT_DISABLE_BIT = 5;
	localparam int EXC_PENDING_BIT = 6;
	localparam logic [31:0] PSW_RST = 32'h0000_0020;
	// Fixed register roles
	localparam logic [4:0] SP_IDX = 5'h03;
	localparam logic [4:0] EP_IDX = 5'h1E;
	// Opcode fields
	localparam logic [5:0] OP_XOR = 6'h09;
	localparam logic [5:0] OP_TST = 6'h0B;
	localparam logic [5:0] OP_REVERSE_SUBTRACT = 6'h0C;
	localparam logic [5:0] OP_SUB = 6'h0D;
	localparam logic [5:0] OP_XOR_IMMEDIATE = 6'h35;
	localparam logic [5:0] OP_LDW = 6'h39;
	localparam logic [5:0] OP_BIT = 6'h3E;
	localparam logic [5:0] OP_EXT = 6'h3F;
	localparam logic [10:0] OP_SWITCH = 11'h002;
	localparam logic [10:0] OP_ZXB = 11'h004;
	localparam logic [10:0] OP_SXB = 11'h005;
	localparam logic [10:0] OP_ZXH = 11'h006;
	localparam logic [10:0] OP_SXH = 11'h007;
	localparam logic [10:0] OP_TRAP = 11'h03F;
	localparam logic [9:0] OP_PREP = 10'h01E;
	localparam logic [2:0] PREP_SUB = 3'h3;
	localparam logic [3:0] OP_SLDW = 4'hA;
	localparam logic [15:0] SUB_TRAP = 16'h0100;
	localparam logic [15:0] SUB_STSR = 16'h0040;
	localparam logic [15:0] SUB_LDSR = 16'h0020;
	localparam logic [15:0] SUB_BTST = 16'h00E6;
	// Element pointer source selections
	localparam logic [1:0] EPS_SP = 2'h0;
	localparam logic [1:0] EPS_SEXT = 2'h1;
	localparam logic [1:0] EPS_HI = 2'h2;
	localparam logic [1:0] EPS_I32 = 2'h3;
	// Trap handler addresses and cause codes
	localparam logic [31:0] TRAP_VEC_LO = 32'h0000_0040;
	localparam logic [31:0] TRAP_VEC_HI = 32'h0000_0050;
	localparam logic [4:0] TRAP_HI_MIN = 5'h10;
	localparam logic [15:0] TRAP_CODE_BASE = 16'h0040;
	localparam logic [31:0] PC_STEP2 = 32'h0000_0002;
	localparam logic [31:0] PC_STEP4 = 32'h0000_0004;
	// Clock counts with no wait states
	localparam logic [4:0] CYC_1 = 5'h01;
	localparam logic [4:0] CYC_LD2 = 5'h02;
	localparam logic [4:0] CYC_3 = 5'h03;
	localparam logic [4:0] CYC_SWITCH = 5'h05;
	// Memory access sizes
	localparam logic [1:0] MSZ_B = 2'h0;
	localparam logic [1:0] MSZ_H = 2'h1;
	localparam logic [1:0] MSZ_W = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_HOLD} cte_state_t;
	typedef enum logic [2:0] {K_NONE, K_ALU, K_SWITCH, K_TRAP, K_BTST, K_LOAD, K_LDSR} cte_kind_t;
endpackage : cte_pkg

// ---- hw/cte_exec.sv ----
// Operation
// - Table jump: indexed halfword, five clocks
// - Sign-extend byte or half, one clock
// - Zero-extend byte, one clock, flags kept
// - Zero-extend half, one clock, flags kept
// - Trap saves PC+4, status, cause, sets bits
// - Trap vector selects low or high handler
// - Bit test displacement form sets Z inverted
// - Bit test register form sets Z inverted
// - XOR immediate zero-extended, flags updated
// - Bit tests take three plus wait states
// - Status-dependent instruction three after PROGRAM_STATUS_WORD write
// - Element-pointer loads one clock plus waits
// - Two-clock loads lengthened by wait states
// - List count n, zero treated as one
// - Immediate-32 element pointer adds three clocks
// - Two-bit source field picks element pointer value
// - Source field sits in bits 19 and 20
// - System register load reads reg1 field
`timescale 1ns/1ns
module cte_exec
	import cte_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] instr_ext_i,
	input wire logic [31:0] instr_pc_i,
	output logic ready_o,
	output logic mem_req_o,
	output logic [31:0] mem_addr_o,
	output logic [1:0] mem_size_o,
	input wire logic mem_ack_i,
	input wire logic [31:0] mem_rdata_i,
	output logic redirect_o,
	output logic [31:0] redirect_pc_o,
	input wire logic [5:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o
);
	typedef struct packed {
		cte_state_t st;
		cte_kind_t kind;
		logic [4:0] cnt;
		logic [31:0][31:0] gr;
		logic [31:0] program_status_word;
		logic [31:0] exc_return_pc;
		logic [31:0] exc_saved_status;
		logic [31:0] ecr;
		logic [31:0] pc;
		logic [31:0] res;
		logic [4:0] dst;
		logic wr;
		logic [31:0] npsw;
		logic wpsw;
		logic [2:0] bsel;
		logic [4:0] srid;
		logic [31:0] ipc;
		logic [4:0] vec;
		logic psw_dirty;
		logic rdy;
		logic mreq;
		logic [31:0] maddr;
		logic [1:0] msize;
		logic redir;
		logic [31:0] rdata;
	} cte_regs_t;

	cte_regs_t s;
	cte_regs_t next_s;

	// New status word for arithmetic and logic results
	function automatic logic [31:0] alu_flags(input logic [31:0] p, input logic [31:0] r,
		input logic cy, input logic ov, input logic upcy);
		logic [31:0] q;
		q = p;
		q[PSW_Z] = (r == 32'h0000_0000);
		q[PSW_S] = r[31];
		q[PSW_OV] = ov;
		if (upcy) begin
			q[PSW_CY] = cy;
		end
		return q;
	endfunction : alu_flags

	logic [4:0] r1;
	logic [4:0] r2;
	logic [5:0] op6;
	logic [10:0] op11;
	logic [15:0] sub;
	logic [31:0] va;
	logic [31:0] vb;
	logic [32:0] d;
	logic [11:0] list;
	logic [3:0] lcnt;
	logic [4:0] ncyc;
	logic [1:0] ff;
	logic fin;

	// Field split of the incoming instruction
	assign r1 = instr_i[4:0];
	assign r2 = instr_i[15:11];
	assign op6 = instr_i[10:5];
	assign op11 = instr_i[15:5];
	assign sub = instr_i[31:16];
	assign list = {instr_i[31:21], instr_i[0]};
	assign ff = instr_i[20:19];

	// Register list population count
	always_comb begin
		lcnt = 4'h0;
		for (int i = 0; i < 12; i++) begin
			lcnt = lcnt + 4'(list[i]);
		end
	end

	// Next-state logic: decode, memory wait, completion, register port
	always_comb begin
		next_s = s;
		next_s.redir = 1'b0;
		next_s.rdata = 32'h0000_0000;
		va = s.gr[r1];
		vb = s.gr[r2];
		d = 33'h0_0000_0000;
		ncyc = CYC_1;
		fin = 1'b0;
		case (s.st)
			ST_IDLE: begin
				if (instr_valid_i && s.rdy) begin
					// Every instruction lands in HOLD or MEM; one-clock ops finish next edge
					next_s.st = ST_HOLD;
					next_s.rdy = 1'b0;
					next_s.cnt = CYC_1;
					next_s.kind = K_NONE;
					next_s.wr = 1'b0;
					next_s.wpsw = 1'b0;
					next_s.ipc = instr_pc_i;
					next_s.dst = r2;
					if (op11 == OP_SWITCH) begin
						next_s.kind = K_SWITCH;
						next_s.res = instr_pc_i + PC_STEP2;
						next_s.maddr = instr_pc_i + PC_STEP2 + {va[30:0], 1'b0};
						next_s.msize = MSZ_H;
						next_s.mreq = 1'b1;
						next_s.st = ST_MEM;
						next_s.cnt = CYC_SWITCH;
					end else if (op11 == OP_SXB) begin
						next_s.kind = K_ALU;
						next_s.wr = 1'b1;
						next_s.dst = r1;
						next_s.res = {{24{va[7]}}, va[7:0]};
					end else if (op11 == OP_SXH) begin
						next_s.kind = K_ALU;
						next_s.wr = 1'b1;
						next_s.dst = r1;
						next_s.res = {{16{va[15]}}, va[15:0]};
					end else if (op11 == OP_ZXB) begin
						next_s.kind = K_ALU;
						next_s.wr = 1'b1;
						next_s.dst = r1;
						next_s.res = {24'h00_0000, va[7:0]};
					end else if (op11 == OP_ZXH) begin
						next_s.kind = K_ALU;
						next_s.wr = 1'b1;
						next_s.dst = r1;
						next_s.res = {16'h0000, va[15:0]};
					end else if (op11 == OP_TRAP && sub == SUB_TRAP) begin
						next_s.kind = K_TRAP;
						next_s.vec = r1;
						next_s.cnt = CYC_3;
					end else if (instr_i[15:6] == OP_PREP && instr_i[18:16] == PREP_SUB) begin
						// Stack-frame setup: only the element pointer load and timing
						next_s.kind = K_ALU;
						next_s.wr = 1'b1;
						next_s.dst = EP_IDX;
						case (ff)
							EPS_SP: next_s.res = s.gr[SP_IDX];
							EPS_SEXT: next_s.res = {{16{instr_ext_i[15]}}, instr_ext_i[15:0]};
							EPS_HI: next_s.res = {instr_ext_i[15:0], 16'h0000};
							default: next_s.res = instr_ext_i;
						endcase
						ncyc = (lcnt == 4'h0) ? CYC_1 : {1'b0, lcnt};
						if (ff == EPS_I32) begin
							ncyc = ncyc + CYC_3;
						end
						next_s.cnt = ncyc;
					end else begin
						case (op6)
							OP_SUB: begin
								d = {1'b0, vb} - {1'b0, va};
								next_s.kind = K_ALU;
								next_s.wr = 1'b1;
								next_s.res = d[31:0];
								next_s.wpsw = 1'b1;
								next_s.npsw = alu_flags(s.program_status_word, d[31:0], d[32],
									(vb[31] ^ va[31]) & (d[31] ^ vb[31]), 1'b1);
							end
							OP_REVERSE_SUBTRACT: begin
								d = {1'b0, va} - {1'b0, vb};
								next_s.kind = K_ALU;
								next_s.wr = 1'b1;
								next_s.res = d[31:0];
								next_s.wpsw = 1'b1;
								next_s.npsw = alu_flags(s.program_status_word, d[31:0], d[32],
									(va[31] ^ vb[31]) & (d[31] ^ va[31]), 1'b1);
							end
							OP_XOR: begin
								next_s.kind = K_ALU;
								next_s.wr = 1'b1;
								next_s.res = vb ^ va;
								next_s.wpsw = 1'b1;
								next_s.npsw = alu_flags(s.program_status_word, vb ^ va, 1'b0, 1'b0, 1'b0);
							end
							OP_TST: begin
								next_s.kind = K_ALU;
								next_s.wpsw = 1'b1;
								next_s.npsw = alu_flags(s.program_status_word, vb & va, 1'b0, 1'b0, 1'b0);
							end
							OP_XOR_IMMEDIATE: begin
								next_s.kind = K_ALU;
								next_s.wr = 1'b1;
								next_s.res = va ^ {16'h0000, sub};
								next_s.wpsw = 1'b1;
								next_s.npsw = alu_flags(s.program_status_word, va ^ {16'h0000, sub}, 1'b0, 1'b0, 1'b0);
							end
							OP_BIT: begin
								if (instr_i[15:14] == 2'h3) begin
									next_s.kind = K_BTST;
									next_s.bsel = instr_i[13:11];
									next_s.maddr = va + {{16{sub[15]}}, sub};
									next_s.msize = MSZ_B;
									next_s.mreq = 1'b1;
									next_s.st = ST_MEM;
									next_s.cnt = CYC_3;
								end
							end
							OP_LDW: begin
								if (instr_i[16]) begin
									next_s.kind = K_LOAD;
									next_s.maddr = va + {{16{sub[15]}}, sub[15:1], 1'b0};
									next_s.msize = MSZ_W;
									next_s.mreq = 1'b1;
									next_s.st = ST_MEM;
									next_s.cnt = CYC_LD2;
								end
							end
							OP_EXT: begin
								if (sub == SUB_BTST) begin
									next_s.kind = K_BTST;
									next_s.bsel = vb[2:0];
									next_s.maddr = va;
									next_s.msize = MSZ_B;
									next_s.mreq = 1'b1;
									next_s.st = ST_MEM;
									next_s.cnt = CYC_3;
								end else if (sub == SUB_STSR) begin
									next_s.kind = K_ALU;
									next_s.wr = 1'b1;
									case (r1)
										SR_EXC_RETURN_PC: next_s.res = s.exc_return_pc;
										SR_EXC_SAVED_STATUS: next_s.res = s.exc_saved_status;
										SR_ECR: next_s.res = s.ecr;
										SR_PSW: next_s.res = s.program_status_word;
										default: next_s.res = 32'h0000_0000;
									endcase
									// Status read right after a status write waits for it
									next_s.cnt = s.psw_dirty ? CYC_3 : CYC_1;
								end else if (sub == SUB_LDSR) begin
									next_s.kind = K_LDSR;
									next_s.srid = r2;
									next_s.res = va;
								end
							end
							default: begin
								if (instr_i[10:7] == OP_SLDW && !instr_i[0]) begin
									next_s.kind = K_LOAD;
									next_s.maddr = s.gr[EP_IDX] + {24'h00_0000, instr_i[6:1], 2'h0};
									next_s.msize = MSZ_W;
									next_s.mreq = 1'b1;
									next_s.st = ST_MEM;
									next_s.cnt = CYC_1;
								end
							end
						endcase
					end
				end
			end
			ST_MEM: begin
				// Clock count is frozen while the memory inserts wait states
				if (mem_ack_i) begin
					next_s.mreq = 1'b0;
					case (s.kind)
						K_SWITCH: next_s.res = s.res + {{15{mem_rdata_i[15]}}, mem_rdata_i[15:0], 1'b0};
						K_BTST: begin
							next_s.wpsw = 1'b1;
							next_s.npsw = s.program_status_word;
							next_s.npsw[PSW_Z] = ~mem_rdata_i[s.bsel];
						end
						default: begin
							next_s.wr = 1'b1;
							next_s.res = mem_rdata_i;
						end
					endcase
					if (s.cnt == CYC_1) begin
						fin = 1'b1;
					end else begin
						next_s.st = ST_HOLD;
						next_s.cnt = s.cnt - CYC_1;
					end
				end
			end
			ST_HOLD: begin
				if (s.cnt == CYC_1) begin
					fin = 1'b1;
				end else begin
					next_s.cnt = s.cnt - CYC_1;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
				next_s.rdy = 1'b1;
			end
		endcase
		// Completion: instructions change architectural state only here
		if (fin) begin
			next_s.st = ST_IDLE;
			next_s.rdy = 1'b1;
			if (next_s.wr && next_s.dst != 5'h00) begin
				next_s.gr[next_s.dst] = next_s.res;
			end
			if (next_s.wpsw) begin
				next_s.program_status_word = next_s.npsw;
			end
			next_s.psw_dirty = next_s.wpsw;
			case (s.kind)
				K_SWITCH: begin
					next_s.pc = next_s.res;
					next_s.redir = 1'b1;
				end
				K_TRAP: begin
					next_s.exc_return_pc = s.ipc + PC_STEP4;
					next_s.exc_saved_status = s.program_status_word;
					next_s.ecr[15:0] = TRAP_CODE_BASE + {11'h000, s.vec};
					next_s.program_status_word[EXC_PENDING_BIT] = 1'b1;
					next_s.program_status_word[INT_DISABLE_BIT] = 1'b1;
					next_s.psw_dirty = 1'b1;
					next_s.pc = (s.vec >= TRAP_HI_MIN) ? TRAP_VEC_HI : TRAP_VEC_LO;
					next_s.redir = 1'b1;
				end
				K_LDSR: begin
					case (s.srid)
						SR_EXC_RETURN_PC: next_s.exc_return_pc = s.res;
						SR_EXC_SAVED_STATUS: next_s.exc_saved_status = s.res;
						SR_ECR: next_s.ecr = s.res;
						SR_PSW: begin
							next_s.program_status_word = s.res;
							next_s.psw_dirty = 1'b1;
						end
						default: next_s.psw_dirty = 1'b0;
					endcase
				end
				default: next_s.kind = s.kind;
			endcase
		end
		// Software port; a write here overrides a completion in the same cycle
		if (reg_wr_i) begin
			if (reg_addr_i <= ADDR_GR_END) begin
				if (reg_addr_i[4:0] != 5'h00) begin
					next_s.gr[reg_addr_i[4:0]] = reg_wdata_i;
				end
			end else begin
				case (reg_addr_i)
					ADDR_PSW: next_s.program_status_word = reg_wdata_i;
					ADDR_EXC_RETURN_PC: next_s.exc_return_pc = reg_wdata_i;
					ADDR_EXC_SAVED_STATUS: next_s.exc_saved_status = reg_wdata_i;
					ADDR_ECR: next_s.ecr = reg_wdata_i;
					default: next_s.rdata = 32'h0000_0000;
				endcase
			end
		end
		if (reg_rd_i) begin
			if (reg_addr_i <= ADDR_GR_END) begin
				next_s.rdata = s.gr[reg_addr_i[4:0]];
			end else begin
				case (reg_addr_i)
					ADDR_PSW: next_s.rdata = s.program_status_word;
					ADDR_EXC_RETURN_PC: next_s.rdata = s.exc_return_pc;
					ADDR_EXC_SAVED_STATUS: next_s.rdata = s.exc_saved_status;
					ADDR_ECR: next_s.rdata = s.ecr;
					ADDR_PC: next_s.rdata = s.pc;
					ADDR_STAT: next_s.rdata = {30'h0000_0000, s.psw_dirty, ~s.rdy};
					default: next_s.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.kind <= K_NONE;
			s.program_status_word <= PSW_RST;
			s.rdy <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// All outputs straight from the state register
	assign ready_o = s.rdy;
	assign mem_req_o = s.mreq;
	assign mem_addr_o = s.maddr;
	assign mem_size_o = s.msize;
	assign redirect_o = s.redir;
	assign redirect_pc_o = s.pc;
	assign reg_rdata_o = s.rdata;
endmodule : cte_exec

// ---- sim/cte_mem_model.sv ----
`timescale 1ns/1ns
// Data memory: the word at an address is {addr[15:0], ~addr[15:0]}
module cte_mem_model (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [31:0] addr_i,
	input wire logic [31:0] waits_i,
	output logic ack_o,
	output logic [31:0] rdata_o
);
	logic [31:0] cnt = 32'h0;
	logic [31:0] junk = 32'h5A5A_C3C3;
	// Data only in the ack cycle; a moving pattern otherwise exposes stale reads
	always_comb begin
		ack_o = req_i && (cnt == waits_i);
		rdata_o = ack_o ? {addr_i[15:0], ~addr_i[15:0]} : junk;
	end
	// Wait counter restarts once a request is answered
	always @(posedge clk_i) begin
		junk <= {junk[30:0], ~junk[31]};
		cnt <= (req_i && !ack_o) ? cnt + 32'h1 : 32'h0;
	end
endmodule : cte_mem_model

// ---- sim/cte_exec_assertions.sv ----
`timescale 1ns/1ns
module cte_exec_chk
	import cte_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic ready_o,
	input wire logic mem_req_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic [1:0] mem_size_o,
	input wire logic mem_ack_i,
	input wire logic redirect_o,
	input wire logic [31:0] redirect_pc_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic take, alu1, ext1, trap, swj, btst;
	// Own decode of the take edge, independent of the design's decoder
	assign take = instr_valid_i && ready_o;
	assign alu1 = take && (instr_i[10:5] inside {OP_SUB, OP_REVERSE_SUBTRACT, OP_XOR, OP_TST, OP_XOR_IMMEDIATE});
	assign ext1 = take && (instr_i[15:5] inside {OP_ZXB, OP_SXB, OP_ZXH, OP_SXH});
	assign trap = take && instr_i[15:5] == OP_TRAP && instr_i[31:16] == SUB_TRAP;
	assign swj = take && instr_i[15:5] == OP_SWITCH;
	assign btst = take && instr_i[15:14] == 2'h3 && instr_i[10:5] == OP_BIT;
	property trap_vec_p;
		logic hi;
		(trap, hi = instr_i[4]) |-> ##4 redirect_pc_o == (hi ? TRAP_VEC_HI : TRAP_VEC_LO);
	endproperty
	alu_one_clock_a: assert property (alu1 |=> !ready_o ##1 ready_o)
		else $error("alu op not one clock");
	ext_one_clock_a: assert property (ext1 |=> !ready_o ##1 ready_o)
		else $error("extend op not one clock");
	trap_three_clock_a: assert property (trap |=> !ready_o [*3] ##1 (ready_o && redirect_o))
		else $error("trap not three clocks");
	trap_vector_a: assert property (trap_vec_p)
		else $error("trap handler address wrong");
	switch_half_read_a: assert property (swj |=> mem_req_o && mem_size_o == MSZ_H)
		else $error("table jump read not halfword");
	switch_five_a: assert property (swj ##1 mem_ack_i |=> !ready_o [*4]
		##1 (ready_o && redirect_o))
		else $error("table jump not five clocks");
	btst_three_a: assert property (btst ##1 mem_ack_i |=> !ready_o [*2] ##1 ready_o)
		else $error("bit test not three clocks");
	mem_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
		&& $stable(mem_addr_o) && $stable(mem_size_o))
		else $error("read request dropped during wait");
	btst_byte_read_a: assert property (btst |=> mem_req_o && mem_size_o == MSZ_B)
		else $error("bit test read not byte");
	redirect_pulse_a: assert property (redirect_o |=> !redirect_o)
		else $error("redirect longer than one cycle");
	cover property (trap);
	cover property (swj ##1 mem_ack_i);
	cover property (btst ##1 !mem_ack_i);
endmodule : cte_exec_chk
bind cte_exec cte_exec_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
	.instr_i(instr_i), .ready_o(ready_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
	.mem_size_o(mem_size_o), .mem_ack_i(mem_ack_i), .redirect_o(redirect_o),
	.redirect_pc_o(redirect_pc_o));

// ---- sim/cte_exec_tb.sv ----
`timescale 1ns/1ns
module cte_exec_tb;
	import cte_pkg::*;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic vld = 1'h0;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic [5:0] ra = 6'h0;
	logic [31:0] ins = 32'h0, ext = 32'h0, pc = 32'h0, wd = 32'h0, waits = 32'h0;
	wire logic rdy, req, ack, redir;
	wire logic [1:0] sz;
	wire logic [31:0] adr, rdat, rpc, rdo;
	int errors = 0, samples_checked = 0, seed = 93241, cyc = 0, n;
	logic [31:0] a, b, v, t;
	logic [35:0] f;
	logic [4:0] vec;
	logic [5:0] op;
	logic [5:0] alu_ops [5] = '{OP_SUB, OP_REVERSE_SUBTRACT, OP_XOR, OP_TST, OP_XOR_IMMEDIATE};
	logic [10:0] ext_ops [4] = '{OP_ZXB, OP_SXB, OP_ZXH, OP_SXH};
	always #2 clk_i = ~clk_i;
	cte_exec dut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(vld), .instr_i(ins),
		.instr_ext_i(ext), .instr_pc_i(pc), .ready_o(rdy), .mem_req_o(req), .mem_addr_o(adr),
		.mem_size_o(sz), .mem_ack_i(ack), .mem_rdata_i(rdat), .redirect_o(redir),
		.redirect_pc_o(rpc), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdo));
	cte_mem_model mem (.clk_i(clk_i), .req_i(req), .addr_i(adr), .waits_i(waits), .ack_o(ack),
		.rdata_o(rdat));
	// Result and {cy, ov, s, z} of the one-clock ALU ops
	function automatic logic [35:0] alu(input logic [5:0] o, input logic [31:0] r1,
		input logic [31:0] r2);
		logic [31:0] x, y, r;
		logic [32:0] d;
		logic s;
		x = (o == OP_REVERSE_SUBTRACT) ? r1 : r2;
		y = (o == OP_REVERSE_SUBTRACT) ? r2 : r1;
		d = {1'h0, x} - {1'h0, y};
		s = (o == OP_SUB) || (o == OP_REVERSE_SUBTRACT);
		r = (o == OP_TST) ? r1 & r2 : (s ? d[31:0] : r1 ^ r2);
		return {s & d[32], s & (x[31] != y[31]) & (r[31] != x[31]), r[31], r == 32'h0, r};
	endfunction : alu
	function automatic logic [31:0] mdat(input logic [31:0] ad);
		return {ad[15:0], ~ad[15:0]};
	endfunction : mdat
	task end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wreg(input logic [5:0] ad, input logic [31:0] d);
		@(posedge clk_i);
		ra <= ad;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk_i);
		wr <= 1'h0;
	endtask : wreg
	// Read data stand only in the cycle after the strobe
	task rreg(input logic [5:0] ad, input logic [31:0] exp);
		@(posedge clk_i);
		ra <= ad;
		rd <= 1'h1;
		@(posedge clk_i);
		rd <= 1'h0;
		#1 chk(rdo, exp);
	endtask : rreg
	// One instruction; n counts the cycles with ready low
	task exec(input logic [31:0] i, input logic [31:0] e, input logic [31:0] p);
		@(posedge clk_i);
		ins <= i;
		ext <= e;
		pc <= p;
		vld <= 1'h1;
		@(posedge clk_i);
		vld <= 1'h0;
		n = 0;
		#1;
		while (rdy !== 1'h1 && n < 40) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask : exec
	// Hang guard, far above the several hundred cycles the run needs
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test;
		end
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'h0;
		rreg(ADDR_PSW, PSW_RST);
		wreg(6'h00, 32'hFFFF_FFFF);
		rreg(6'h00, 32'h0);
		rreg(6'h3F, 32'h0);
		$display("regs done");
		// Overflow corner, then equal operands, then random
		for (int k = 0; k < 25; k++) begin
			op = alu_ops[k % 5];
			a = (k < 5) ? 32'h1 : $random(seed);
			b = (k < 5) ? 32'h8000_0000 : ((k < 10) ? a : $random(seed));
			wreg(6'h01, a);
			wreg(6'h02, b);
			wreg(ADDR_PSW, 32'h0);
			exec({b[15:0], 5'h02, op, 5'h01}, 32'h0, 32'h0);
			chk(n, 1);
			f = alu(op, a, (op == OP_XOR_IMMEDIATE) ? {16'h0, b[15:0]} : b);
			rreg(6'h02, (op == OP_TST) ? b : f[31:0]);
			rreg(ADDR_PSW, {28'h0, f[35:32]});
		end
		$display("alu done");
		// Sign bits forced on and off; flags must survive
		for (int k = 0; k < 8; k++) begin
			v = k[2] ? ($random(seed) | 32'h0000_8080) : ($random(seed) & 32'hFFFF_7F7F);
			wreg(6'h05, v);
			wreg(ADDR_PSW, 32'h0000_000F);
			exec({16'h0, ext_ops[k % 4], 5'h05}, 32'h0, 32'h0);
			case (k % 4)
				0: t = {24'h0, v[7:0]};
				1: t = {{24{v[7]}}, v[7:0]};
				2: t = {16'h0, v[15:0]};
				default: t = {{16{v[15]}}, v[15:0]};
			endcase
			rreg(6'h05, t);
			rreg(ADDR_PSW, 32'h0000_000F);
		end
		$display("extend done");
		for (int k = 0; k < 4; k++) begin
			a = $random(seed) & 32'h0000_00FF;
			b = $random(seed) & 32'h0000_FFFE;
			wreg(6'h04, a);
			exec({16'h0, OP_SWITCH, 5'h04}, 32'h0, b);
			v = mdat(b + 32'h2 + (a << 1));
			chk(n, 5);
			chk(rpc, b + 32'h2 + {{15{v[15]}}, v[15:0], 1'h0});
		end
		$display("switch done");
		// Vectors 00, 0F, 10, 1F: both edges of both handler ranges
		for (int k = 0; k < 4; k++) begin
			vec = {k[1], {4{k[0]}}};
			a = $random(seed) & 32'h0000_000F;
			b = $random(seed) & 32'h00FF_FFFE;
			wreg(ADDR_PSW, a);
			exec({SUB_TRAP, OP_TRAP, vec}, 32'h0, b);
			chk(n, 3);
			chk(rpc, vec[4] ? TRAP_VEC_HI : TRAP_VEC_LO);
			rreg(ADDR_PC, vec[4] ? TRAP_VEC_HI : TRAP_VEC_LO);
			rreg(ADDR_EXC_RETURN_PC, b + 32'h4);
			rreg(ADDR_EXC_SAVED_STATUS, a);
			rreg(ADDR_PSW, a | 32'h0000_0060);
			rreg(ADDR_ECR, {16'h0, TRAP_CODE_BASE + vec});
		end
		// Trap rewrote the status word, so the next status read waits
		exec({SUB_STSR, 5'h0D, OP_EXT, SR_EXC_RETURN_PC}, 32'h0, 32'h0);
		chk(n, 3);
		rreg(6'h0D, b + 32'h4);
		$display("trap done");
		// Memory ops with zero, one and two wait states
		for (int w = 0; w < 3; w++) begin
			waits <= w;
			a = $random(seed);
			b = $random(seed);
			v = $random(seed) & 32'h7;
			wreg(6'h06, a);
			wreg(6'h07, v);
			wreg(ADDR_PSW, 32'h0);
			exec({b[15:0], 2'h3, v[2:0], OP_BIT, 5'h06}, 32'h0, 32'h0);
			t = mdat(a + {{16{b[15]}}, b[15:0]});
			chk(n, 3 + w);
			rreg(ADDR_PSW, {31'h0, ~t[v]});
			exec({SUB_BTST, 5'h07, OP_EXT, 5'h06}, 32'h0, 32'h0);
			t = mdat(a);
			chk(n, 3 + w);
			rreg(ADDR_PSW, {31'h0, ~t[v]});
			exec({b[15:1], 1'h1, 5'h0A, OP_LDW, 5'h06}, 32'h0, 32'h0);
			chk(n, 2 + w);
			rreg(6'h0A, mdat(a + {{16{b[15]}}, b[15:1], 1'h0}));
			wreg({1'h0, EP_IDX}, a);
			exec({16'h0, 5'h0B, OP_SLDW, b[5:0], 1'h0}, 32'h0, 32'h0);
			chk(n, 1 + w);
			rreg(6'h0B, mdat(a + {24'h0, b[5:0], 2'h0}));
		end
		$display("memory done");
		// Status write straight before a status-dependent read
		wreg(6'h05, 32'h0);
		wreg(6'h08, 32'h0000_000B);
		exec({SUB_LDSR, SR_PSW, OP_EXT, 5'h08}, 32'h0, 32'h0);
		rreg(ADDR_STAT, 32'h0000_0002);
		exec({SUB_STSR, 5'h09, OP_EXT, SR_PSW}, 32'h0, 32'h0);
		chk(n, 3);
		exec({SUB_STSR, 5'h0C, OP_EXT, SR_PSW}, 32'h0, 32'h0);
		chk(n, 1);
		rreg(6'h09, 32'h0000_000B);
		rreg(ADDR_PSW, 32'h0000_000B);
		$display("sysreg done");
		// Every source selection; the 32-bit one with an empty list
		v = $random(seed);
		wreg({1'h0, SP_IDX}, v);
		for (int s = 0; s < 4; s++) begin
			b = (s == 3) ? 32'h0 : $random(seed) & 32'h0000_0FFF;
			a = $random(seed) | 32'h0000_8000;
			exec({b[11:1], s[1:0], PREP_SUB, OP_PREP, 5'h0, b[0]}, a, 32'h0);
			t = ($countones(b[11:0]) > 0) ? $countones(b[11:0]) : 1;
			chk(n, t + ((s == 3) ? 3 : 0));
			case (s)
				0: t = v;
				1: t = {{16{a[15]}}, a[15:0]};
				2: t = {a[15:0], 16'h0};
				default: t = a;
			endcase
			rreg({1'h0, EP_IDX}, t);
		end
		$display("frame done");
		end_of_test;
	end
endmodule : cte_exec_tb
